// *** rtl/aad_defines.svh ***
// constants for the address attribute decode block
`ifndef AAD_DEFINES_SVH
`define AAD_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define AAD_OFS_CH0       12'h000
`define AAD_OFS_LAST      12'h00C
`define AAD_IDX_HI        3
`define AAD_IDX_LO        2
`define AAD_CFG_RST       24'h000000
`define AAD_WMASK         24'hFFFFBC

// ****************************************************************
// channel register fields
// ****************************************************************
`define AAD_BAC_HI        23
`define AAD_BAC_LO        12
`define AAD_BNC_HI        11
`define AAD_BNC_LO        8
`define AAD_PACK_BIT      7
`define AAD_YEN_BIT       5
`define AAD_XEN_BIT       4
`define AAD_PEN_BIT       3
`define AAD_POL_BIT       2
`define AAD_BNC_ALL       4'h0
`define AAD_BAC_ONES      12'hFFF

// ****************************************************************
// packing
// ****************************************************************
`define AAD_BYTE_FIRST    2'h0
`define AAD_BYTE_STEP     2'h1
`define AAD_BYTE_LAST     2'h2
`define AAD_ATTR_IDLE_RST 4'hF

`endif

// *** rtl/aad_pkg.sv ***
// types shared by the address attribute decode block
package aad_pkg;

   typedef logic [23:0] aad_word_t;

   typedef enum logic [1:0] {
      AAD_SP_P,
      AAD_SP_X,
      AAD_SP_Y
   } aad_space_e;

   typedef enum logic {
      AAD_ST_IDLE,
      AAD_ST_BUS
   } aad_state_e;

endpackage : aad_pkg

// *** rtl/aad_chan_if.sv ***
// carrier between the sequencer and one channel matcher
interface aad_chan_if;
   import aad_pkg::*;

   aad_word_t  cfg;
   aad_word_t  addr;
   aad_space_e space;
   logic       hit;

   modport mtch (input cfg, input addr, input space, output hit);
   modport drv  (output cfg, output addr, output space, input hit);

endinterface : aad_chan_if

// *** rtl/aad_match.sv ***
// one address attribute channel matcher
`include "aad_defines.svh"

module aad_match
   import aad_pkg::*;
#(
   parameter aad_word_t INT_TOP = 24'h010000
)(
   // channel carrier
   aad_chan_if.mtch chan
);

   logic [3:0]  cnt;
   logic [11:0] mask;
   logic        sp_en;
   logic        addr_ok;

   always_comb begin
      cnt  = chan.cfg[`AAD_BNC_HI:`AAD_BNC_LO];
      // counts above twelve saturate to a full compare
      mask = ~(`AAD_BAC_ONES >> cnt);
      case (chan.space)
         AAD_SP_P: sp_en = chan.cfg[`AAD_PEN_BIT];
         AAD_SP_X: sp_en = chan.cfg[`AAD_XEN_BIT];
         AAD_SP_Y: sp_en = chan.cfg[`AAD_YEN_BIT];
         default:  sp_en = 1'b0;
      endcase
      if (cnt == `AAD_BNC_ALL) begin
         addr_ok = (chan.addr >= INT_TOP);
      end else begin
         // upper twelve of the full 24-bit address, any mode
         addr_ok = ((chan.addr[`AAD_BAC_HI:`AAD_BAC_LO]
                    ^ chan.cfg[`AAD_BAC_HI:`AAD_BAC_LO]) & mask) == 12'h000;
      end
   end

   assign chan.hit = sp_en & addr_ok;

endmodule : aad_match

// *** rtl/aad_top.sv ***
// address attribute decode: registers, access sequencer, strobe pins
//
// Contract
// - strobe a channel only on prefix match in an enabled space
// - compare field bits 23-12 give the top twelve address bits
// - same upper twelve-bit compare in 16-bit compatibility mode
// - count field bits 11-8 picks how many top bits compare
// - count zero matches whole space, outside internal memory only
// - packing bit 7 splits a dma access into three at +0,+1,+2
// - bytes little endian: low first and lowest, high last
// - packed bytes use only the eight low data lines
// - without packing one 24-bit access per word
// - packing applies to dma accesses only, never core
// - full address driven every access, no row/column multiplexing
// - bits 5,4,3 enable y, x and program space matching
// - bit 2 sets strobe level: clear low, set high
// - three packed bytes hold the bus as one access
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "aad_defines.svh"

module aad_top
   import aad_pkg::*;
#(
   parameter int        NCH     = 4,
   parameter aad_word_t INT_TOP = 24'h010000
)(
   // clock and reset
   input  logic             clock_i,
   input  logic             resetn_i,
   // apb slave
   input  logic             psel_i,
   input  logic             penable_i,
   input  logic             pwrite_i,
   input  logic [11:0]      paddr_i,
   input  logic [31:0]      pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // core access request
   input  logic             core_req_i,
   input  logic             core_we_i,
   input  aad_word_t        core_addr_i,
   input  aad_space_e       core_space_i,
   input  aad_word_t        core_wdata_i,
   output logic             core_done_o,
   // dma access request
   input  logic             dma_req_i,
   input  logic             dma_we_i,
   input  aad_word_t        dma_address_bus_i,
   input  aad_space_e       dma_space_i,
   input  aad_word_t        dma_wdata_i,
   output logic             dma_done_o,
   // read answer to either requester
   output aad_word_t        rdata_o,
   // external port
   output logic             ext_cycle_o,
   output logic             ext_we_o,
   output logic             ext_lock_o,
   output aad_word_t        ext_addr_o,
   output aad_space_e       ext_space_o,
   output aad_word_t        ext_wdata_o,
   input  aad_word_t        ext_rdata_i,
   input  logic             ext_ready_i,
   output logic [NCH-1:0]   attribute_strobe_pin_o
);

   // ****************************************************************
   // apb register file
   // ****************************************************************
   aad_word_t  cfg_ff [NCH];
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        wr_en;

   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = (a <= `AAD_OFS_LAST) && (a[1:0] == 2'h0);
   endfunction : reg_hit

   function automatic logic [1:0] reg_idx(input logic [11:0] a);
      reg_idx = a[`AAD_IDX_HI:`AAD_IDX_LO];
   endfunction : reg_idx

   // zero-wait slave: ready rises in the first access cycle
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel_i & ~penable_i;
         pslverr_ff <= psel_i & ~penable_i & ~reg_hit(paddr_i);
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel_i & ~penable_i & ~pwrite_i & reg_hit(paddr_i)) begin
         prdata_ff <= {8'h00, cfg_ff[reg_idx(paddr_i)]};
      end else if (psel_i & ~penable_i) begin
         prdata_ff <= 32'h0000_0000;
      end
   end

   assign wr_en = psel_i & penable_i & pready_ff & pwrite_i & reg_hit(paddr_i);

   // ****************************************************************
   // access sequencer state
   // ****************************************************************
   aad_state_e  state_ff;
   aad_state_e  nxt_state;
   aad_word_t   base_ff;
   aad_word_t   wdata_ff;
   aad_word_t   asm_ff;
   aad_space_e  space_ff;
   logic        we_ff;
   logic        dma_ff;
   logic        pack_ff;
   logic [1:0]  idx_ff;
   aad_word_t   iss_addr;
   aad_space_e  iss_space;
   logic        take_core;
   logic        take_dma;
   logic        more;
   logic        last;
   logic [NCH-1:0] hit;
   logic [NCH-1:0] pack_en;
   logic [NCH-1:0] pol;
   logic [NCH-1:0] nxt_act;
   logic [NCH-1:0] act_ff;
   logic        nxt_pack;

   assign take_core = (state_ff == AAD_ST_IDLE) & core_req_i;
   assign take_dma  = (state_ff == AAD_ST_IDLE) & ~core_req_i & dma_req_i;
   assign more      = pack_ff & (idx_ff != `AAD_BYTE_LAST);
   assign last      = (state_ff == AAD_ST_BUS) & ext_ready_i & ~more;

   // address of the access on the pins next cycle, fed to every matcher
   always_comb begin
      iss_addr  = base_ff + {22'h000000, idx_ff};
      iss_space = space_ff;
      if (take_core) begin
         iss_addr  = core_addr_i;
         iss_space = core_space_i;
      end else if (take_dma) begin
         iss_addr  = dma_address_bus_i;
         iss_space = dma_space_i;
      end else if ((state_ff == AAD_ST_BUS) & ext_ready_i & more) begin
         iss_addr  = base_ff + {22'h000000, idx_ff + `AAD_BYTE_STEP};
      end
   end

   // ****************************************************************
   // channels
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         aad_chan_if chan ();

         always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
               cfg_ff[g] <= `AAD_CFG_RST;
            end else if (wr_en && (reg_idx(paddr_i) == 2'(g))) begin
               cfg_ff[g] <= pwdata_i[23:0] & `AAD_WMASK;
            end
         end

         assign chan.cfg   = cfg_ff[g];
         assign chan.addr  = iss_addr;
         assign chan.space = iss_space;
         assign hit[g]     = chan.hit;
         assign pack_en[g] = cfg_ff[g][`AAD_PACK_BIT];
         assign pol[g]     = cfg_ff[g][`AAD_POL_BIT];

         aad_match #(.INT_TOP(INT_TOP)) u_match (
            .chan (chan.mtch)
         );
      end
   endgenerate

   // a dma access packs when a channel matching its first address says so
   assign nxt_pack = take_dma & |(hit & pack_en);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         AAD_ST_IDLE: begin
            if (take_core | take_dma) begin
               nxt_state = AAD_ST_BUS;
            end
         end
         AAD_ST_BUS: begin
            if (last) begin
               nxt_state = AAD_ST_IDLE;
            end
         end
         default: nxt_state = AAD_ST_IDLE;
      endcase
   end

   assign nxt_act = (nxt_state == AAD_ST_BUS) ? hit : '0;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= AAD_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************************************
   // request capture
   // ****************************************************************
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         base_ff  <= 24'h000000;
         wdata_ff <= 24'h000000;
         space_ff <= AAD_SP_P;
         we_ff    <= 1'b0;
         dma_ff   <= 1'b0;
         pack_ff  <= 1'b0;
      end else if (take_core) begin
         base_ff  <= core_addr_i;
         wdata_ff <= core_wdata_i;
         space_ff <= core_space_i;
         we_ff    <= core_we_i;
         dma_ff   <= 1'b0;
         pack_ff  <= 1'b0;
      end else if (take_dma) begin
         base_ff  <= dma_address_bus_i;
         wdata_ff <= dma_wdata_i;
         space_ff <= dma_space_i;
         we_ff    <= dma_we_i;
         dma_ff   <= 1'b1;
         pack_ff  <= nxt_pack;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         idx_ff <= `AAD_BYTE_FIRST;
      end else if (take_core | take_dma) begin
         idx_ff <= `AAD_BYTE_FIRST;
      end else if ((state_ff == AAD_ST_BUS) & ext_ready_i & more) begin
         idx_ff <= idx_ff + `AAD_BYTE_STEP;
      end
   end

   // read assembly: byte n lands in lane n, lowest address first
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         asm_ff <= 24'h000000;
      end else if ((state_ff == AAD_ST_BUS) & ext_ready_i) begin
         if (!pack_ff) begin
            asm_ff <= ext_rdata_i;
         end else begin
            case (idx_ff)
               2'h0:    asm_ff[7:0]   <= ext_rdata_i[7:0];
               2'h1:    asm_ff[15:8]  <= ext_rdata_i[7:0];
               default: asm_ff[23:16] <= ext_rdata_i[7:0];
            endcase
         end
      end
   end

   // ****************************************************************
   // external port outputs
   // ****************************************************************
   aad_word_t nxt_wdata;

   always_comb begin
      nxt_wdata = wdata_ff;
      if (take_core) begin
         nxt_wdata = core_wdata_i;
      end else if (take_dma & nxt_pack) begin
         nxt_wdata = {16'h0000, dma_wdata_i[7:0]};
      end else if (take_dma) begin
         nxt_wdata = dma_wdata_i;
      end else if (pack_ff & (idx_ff == `AAD_BYTE_FIRST)) begin
         nxt_wdata = {16'h0000, wdata_ff[15:8]};
      end else if (pack_ff) begin
         nxt_wdata = {16'h0000, wdata_ff[23:16]};
      end
   end

   logic       cyc_ff;
   logic       lock_ff;
   aad_word_t  eaddr_ff;
   aad_word_t  ewdata_ff;
   aad_space_e espace_ff;
   logic       ewe_ff;
   logic [NCH-1:0] attr_ff;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cyc_ff    <= 1'b0;
         lock_ff   <= 1'b0;
         eaddr_ff  <= 24'h000000;
         ewdata_ff <= 24'h000000;
         espace_ff <= AAD_SP_P;
         ewe_ff    <= 1'b0;
      end else begin
         cyc_ff  <= (nxt_state == AAD_ST_BUS);
         // held across all three bytes so arbitration cannot split them
         lock_ff <= (nxt_state == AAD_ST_BUS)
                    & (nxt_pack | (pack_ff & (state_ff == AAD_ST_BUS)));
         if ((take_core | take_dma) | ((state_ff == AAD_ST_BUS) & ext_ready_i & more)) begin
            eaddr_ff  <= iss_addr;
            ewdata_ff <= nxt_wdata;
            espace_ff <= iss_space;
            ewe_ff    <= take_core ? core_we_i : (take_dma ? dma_we_i : we_ff);
         end
      end
   end

   // idle level follows polarity, so a polarity write shows one clock later
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_ff  <= '0;
         attr_ff <= `AAD_ATTR_IDLE_RST;
      end else begin
         act_ff  <= nxt_act;
         attr_ff <= nxt_act ~^ pol;
      end
   end

   // ****************************************************************
   // answers
   // ****************************************************************
   logic core_done_ff;
   logic dma_done_ff;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         core_done_ff <= 1'b0;
         dma_done_ff  <= 1'b0;
      end else begin
         core_done_ff <= last & ~dma_ff;
         dma_done_ff  <= last & dma_ff;
      end
   end

   assign prdata_o               = prdata_ff;
   assign pready_o               = pready_ff;
   assign pslverr_o              = pslverr_ff;
   assign core_done_o            = core_done_ff;
   assign dma_done_o             = dma_done_ff;
   assign rdata_o                = asm_ff;
   assign ext_cycle_o            = cyc_ff;
   assign ext_we_o               = ewe_ff;
   assign ext_lock_o             = lock_ff;
   assign ext_addr_o             = eaddr_ff;
   assign ext_space_o            = espace_ff;
   assign ext_wdata_o            = ewdata_ff;
   assign attribute_strobe_pin_o = attr_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_STROBE_IN_CYCLE: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (|act_ff) |-> ext_cycle_o)
      else $error("attribute strobe active outside an external cycle");

   AST_IDLE_LEVEL: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      !ext_cycle_o |-> attribute_strobe_pin_o == ~$past(pol))
      else $error("strobe not at its idle level between cycles");

   AST_PACK_STEP: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (ext_cycle_o && ext_ready_i && pack_ff && idx_ff != `AAD_BYTE_LAST)
      |=> ext_cycle_o && ext_addr_o == $past(ext_addr_o) + 24'h000001)
      else $error("packed byte address did not advance by one");

   AST_PACK_LOW_LANE: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (ext_cycle_o && pack_ff) |-> ext_wdata_o[23:8] == 16'h0000)
      else $error("packed byte used upper data lines");

   AST_PACK_DMA_ONLY: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      pack_ff |-> dma_ff)
      else $error("core access was packed");

   AST_SINGLE_WORD: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (ext_cycle_o && ext_ready_i && !pack_ff) |=> !ext_cycle_o)
      else $error("unpacked access did not end after one transfer");

   AST_PACK_HOLD: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (ext_cycle_o && ext_ready_i && pack_ff && idx_ff != `AAD_BYTE_LAST)
      |=> ext_cycle_o && ext_lock_o)
      else $error("bus released inside a packed transfer");

   AST_LOW_BYTE_FIRST: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (ext_cycle_o && ext_ready_i && pack_ff && idx_ff == `AAD_BYTE_FIRST && !ext_we_o)
      |=> asm_ff[7:0] == $past(ext_rdata_i[7:0]))
      else $error("first packed byte not placed in the low lane");

endmodule : aad_top

// *** verification/aad_ext_mem.sv ***
// external word memory model behind the attribute strobes
module aad_ext_mem
   import aad_pkg::*;
(
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   // external port
   input  wire logic       cyc_i,
   input  wire logic       we_i,
   input  wire aad_word_t  addr_i,
   input  wire aad_word_t  wdata_i,
   input  wire logic [3:0] wait_i,
   output logic            ready_o,
   output aad_word_t       rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;

   aad_word_t  mem [256];
   logic [3:0] cnt_ff;

   // upper lines hold junk so byte reads must ignore them
   initial begin
      foreach (mem[i]) mem[i] = {16'hC3C3, i[7:0]};
   end

   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready_o <= 1'b0;
         cnt_ff  <= 4'h0;
         rdata_o <= 24'h5A5A5A;
      end else if (ready_o) begin
         ready_o <= 1'b0;
         cnt_ff  <= 4'h0;
         rdata_o <= ~rdata_o;
         if (cyc_i && we_i) mem[addr_i[7:0]] <= wdata_i;
      end else if (cyc_i && cnt_ff == wait_i) begin
         ready_o <= 1'b1;
         rdata_o <= mem[addr_i[7:0]];
      end else begin
         cnt_ff  <= cyc_i ? cnt_ff + 4'h1 : 4'h0;
         // bus released or still counting wait states: show a toggling pattern, the last word on every other cycle
         rdata_o <= ~rdata_o;
      end
   end
endmodule : aad_ext_mem

// *** verification/test_address_attribute_decode.sv ***
// self-checking bench for the address attribute decode block
module test_address_attribute_decode;
   timeunit 1ns;
   timeprecision 1ns;
   import aad_pkg::*;

   logic clock_i, resetn_i, psel, penable, pwrite, core_req, dma_req, we_r;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_o;
   logic pready_o, pslverr_o, core_done_o, dma_done_o, ext_cycle_o, ext_we_o;
   logic ext_lock_o, ext_ready_i;
   aad_word_t a_r, wd_r, rdata_o, ext_addr_o, ext_wdata_o, ext_rdata_i;
   aad_space_e sp_r, ext_space_o;
   logic [3:0] attribute_strobe_pin_o, wait_r;
   aad_word_t cfg [4];
   aad_word_t qa [$];
   logic [3:0] qp [$];
   logic [7:0] qb [$];
   logic ql [$];
   logic [2:0] qs [$];
   int errors, total_checks, cyc;

   aad_top i_dut (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .core_req_i(core_req), .core_we_i(we_r), .core_addr_i(a_r), .core_space_i(sp_r),
      .core_wdata_i(wd_r), .core_done_o(core_done_o),
      .dma_req_i(dma_req), .dma_we_i(we_r), .dma_address_bus_i(a_r), .dma_space_i(sp_r),
      .dma_wdata_i(wd_r), .dma_done_o(dma_done_o), .rdata_o(rdata_o),
      .ext_cycle_o(ext_cycle_o), .ext_we_o(ext_we_o), .ext_lock_o(ext_lock_o),
      .ext_addr_o(ext_addr_o), .ext_space_o(ext_space_o), .ext_wdata_o(ext_wdata_o),
      .ext_rdata_i(ext_rdata_i), .ext_ready_i(ext_ready_i),
      .attribute_strobe_pin_o(attribute_strobe_pin_o));

   aad_ext_mem i_mem (
      .clock_i(clock_i), .resetn_i(resetn_i), .cyc_i(ext_cycle_o), .we_i(ext_we_o),
      .addr_i(ext_addr_o), .wdata_i(ext_wdata_o), .wait_i(wait_r),
      .ready_o(ext_ready_i), .rdata_o(ext_rdata_i));

   // ****************************************************************
   // clock, timeout, transfer capture
   // ****************************************************************
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         tally_and_finish();
      end
   end

   // one entry per completed external handshake
   always @(negedge clock_i) begin
      if (ext_cycle_o && ext_ready_i) begin
         qa.push_back(ext_addr_o);
         qp.push_back(attribute_strobe_pin_o);
         qb.push_back(ext_wdata_o[7:0]);
         ql.push_back(ext_lock_o);
         qs.push_back({ext_we_o, ext_space_o});
      end
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clock_i);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // this wait ends when pready_o is seen with psel and penable; the bench timeout is the only backstop
      do begin
         @(posedge clock_i);
      end while (!(pready_o && psel && penable));
      rd = prdata_o;
      er = pslverr_o;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic set_cfg(input int c, input aad_word_t v);
      logic [31:0] rd;
      logic er;
      apb(1'b1, 12'(c * 4), {8'h00, v}, rd, er);
      cfg[c] = v & 24'hFFFFBC;
   endtask : set_cfg

   // hits are recomputed from the shadow configuration alone
   function automatic logic [3:0] exp_pins(aad_word_t a, aad_space_e s);
      logic [3:0] p;
      aad_word_t m;
      int n;
      logic hit;
      for (int c = 0; c < 4; c++) begin
         n = (cfg[c][11:8] > 12) ? 12 : int'(cfg[c][11:8]);
         m = ~(24'hFFFFFF >> n);
         hit = (n == 0) ? (a >= 24'h010000) : (((a ^ cfg[c]) & m) == 24'h0);
         hit = hit && cfg[c][3 + int'(s)];
         p[c] = hit ? cfg[c][2] : !cfg[c][2];
      end
      return p;
   endfunction : exp_pins

   task automatic acc(input logic d, input logic w, input aad_word_t a, input aad_space_e s,
                      input aad_word_t v, input int n);
      int k;
      int t;
      k = 0;
      t = 0;
      qa.delete();
      qp.delete();
      qb.delete();
      ql.delete();
      qs.delete();
      @(posedge clock_i);
      we_r     <= w;
      a_r      <= a;
      sp_r     <= s;
      wd_r     <= v;
      core_req <= !d;
      dma_req  <= d;
      while (k < n && t < 60) begin
         @(negedge clock_i);
         t++;
         if (ext_cycle_o && ext_ready_i) k++;
      end
      @(posedge clock_i);
      core_req <= 1'b0;
      dma_req  <= 1'b0;
      t = 0;
      do begin
         @(negedge clock_i);
         t++;
      end while (!(core_done_o | dma_done_o) && t < 20);
      check(d ? dma_done_o : core_done_o, 1'b1);
      check(qa.size(), n);
   endtask : acc

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      logic [31:0] rd;
      logic er;
      check(attribute_strobe_pin_o, 4'hF);
      for (int c = 0; c < 4; c++) begin
         apb(1'b0, 12'(c * 4), 32'h0, rd, er);
         check(er, 1'b0);
         check(rd, 32'h0);
         set_cfg(c, 24'hFFFBFF);
         apb(1'b0, 12'(c * 4), 32'h0, rd, er);
         check(er, 1'b0);
         check(rd, 32'h00FFFBBC);
         set_cfg(c, 24'h000000);
      end
      apb(1'b0, 12'h010, 32'h0, rd, er);
      check(er, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, 12'h002, 32'h00FFFBFF, rd, er);
      check(er, 1'b1);
      apb(1'b0, 12'h000, 32'h0, rd, er);
      check(rd, 32'h0);
      $display("test t_regs done");
   endtask : t_regs

   task automatic t_match();
      aad_word_t  ad [12] = '{24'hA12345, 24'hA12345, 24'hBFFFFF, 24'hC00000,
                              24'h123000, 24'h123FFF, 24'h124000, 24'h010000,
                              24'h00FFFF, 24'h5A0000, 24'h5AFFFF, 24'h5B0000};
      aad_space_e sp [12] = '{AAD_SP_X, AAD_SP_Y, AAD_SP_X, AAD_SP_X, AAD_SP_Y, AAD_SP_Y,
                              AAD_SP_Y, AAD_SP_P, AAD_SP_P, AAD_SP_P, AAD_SP_Y, AAD_SP_X};
      set_cfg(0, 24'hA00310);
      set_cfg(1, 24'h123C24);
      set_cfg(2, 24'h00000C);
      set_cfg(3, 24'h5A0838);
      wait_r <= 4'h0;
      for (int i = 0; i < 12; i++) begin
         acc(i[0], 1'b0, ad[i], sp[i], 24'h0, 1);
         check(qa[0], ad[i]);
         check(qp[0], exp_pins(ad[i], sp[i]));
         check(qs[0], {1'b0, sp[i]});
      end
      $display("test t_match done");
   endtask : t_match

   task automatic t_pack();
      aad_word_t a;
      a = 24'h200010;
      for (int c = 0; c < 4; c++) set_cfg(c, 24'h000000);
      set_cfg(1, 24'h2004A8);
      wait_r <= 4'h3;
      acc(1'b1, 1'b1, a, AAD_SP_Y, 24'hABCDEF, 3);
      for (int k = 0; k < 3; k++) begin
         check(qa[k], a + k);
         check(qb[k], 8'(24'hABCDEF >> (8 * k)));
         check(ql[k], 1'b1);
         check(qp[k], exp_pins(a + k, AAD_SP_Y));
         check(qs[k], {1'b1, AAD_SP_Y});
      end
      acc(1'b1, 1'b0, a, AAD_SP_Y, 24'h0, 3);
      check(rdata_o, 24'hABCDEF);
      acc(1'b1, 1'b0, a + 24'h000003, AAD_SP_Y, 24'h0, 3);
      check(rdata_o, 24'h151413);
      // unpacked dma right after a packed one must not hold the bus
      acc(1'b1, 1'b0, 24'h300000, AAD_SP_Y, 24'h0, 1);
      check(ql[0], 1'b0);
      acc(1'b0, 1'b0, a, AAD_SP_Y, 24'h0, 1);
      check(ql[0], 1'b0);
      $display("test t_pack done");
   endtask : t_pack

   initial begin
      resetn_i = 1'b0;
      {psel, penable, pwrite, core_req, dma_req, we_r} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {a_r, wd_r} = '0;
      sp_r = AAD_SP_P;
      wait_r = 4'h1;
      errors = 0;
      total_checks = 0;
      cyc = 0;
      repeat (16) @(posedge clock_i);
      resetn_i <= 1'b1;
      t_regs();
      t_match();
      t_pack();
      tally_and_finish();
   end
endmodule : test_address_attribute_decode
